// File: hdl/bridge_pkg.sv
package bridge_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W      = 32;
  localparam int ID_W        = 4;
  localparam int UP_DATA_W   = 64;
  localparam int LITE_DATA_W = 32;
  localparam int LEN_W       = 8;
  localparam int SIZE_W      = 3;
  localparam int BURST_W     = 2;
  localparam int PROT_W      = 3;
  localparam int CACHE_W     = 4;
  localparam int RESP_W      = 2;
  localparam int UP_STRB_W   = UP_DATA_W / 8;
  localparam int LITE_STRB_W = LITE_DATA_W / 8;
  localparam int UP_OFF_W    = $clog2(UP_STRB_W);
  localparam int LITE_OFF_W  = $clog2(LITE_STRB_W);
  localparam int LANE_W      = UP_OFF_W - LITE_OFF_W;
  localparam int FIFO_DEPTH  = 8;

  localparam logic [SIZE_W-1:0] LITE_SIZE  = SIZE_W'(LITE_OFF_W);
  localparam logic [ADDR_W-1:0] LITE_BYTES = ADDR_W'(LITE_STRB_W);
  localparam logic [ADDR_W-1:0] ADDR_ONE   = 32'h0000_0001;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [BURST_W-1:0] BURST_FIXED = 2'h0;
  localparam logic [BURST_W-1:0] BURST_WRAP  = 2'h2;
  localparam logic [RESP_W-1:0]  RESP_OKAY   = 2'h0;

  // ****************************************
  // channel carriers
  // ****************************************
  typedef struct packed {
    logic [ID_W-1:0]    id;
    logic [ADDR_W-1:0]  addr;
    logic [LEN_W-1:0]   len;
    logic [SIZE_W-1:0]  size;
    logic [BURST_W-1:0] burst;
    logic               lock;
    logic [CACHE_W-1:0] cache;
    logic [PROT_W-1:0]  prot;
  } up_a_s;

  typedef struct packed {
    logic [UP_DATA_W-1:0] data;
    logic [UP_STRB_W-1:0] strb;
    logic                 last;
  } up_w_s;

  typedef struct packed {
    logic [UP_DATA_W-1:0] data;
    logic [UP_STRB_W-1:0] strb;
  } up_wd_s;

  typedef struct packed {
    logic [ID_W-1:0]      id;
    logic [UP_DATA_W-1:0] data;
    logic [RESP_W-1:0]    resp;
    logic                 last;
  } up_r_s;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic [RESP_W-1:0] resp;
  } resp_s;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic [ADDR_W-1:0] addr;
    logic [SIZE_W-1:0] size;
    logic [PROT_W-1:0] prot;
  } lite_a_s;

  typedef struct packed {
    logic [LITE_DATA_W-1:0] data;
    logic [LITE_STRB_W-1:0] strb;
  } lite_w_s;

  typedef struct packed {
    logic [ID_W-1:0]        id;
    logic [LITE_DATA_W-1:0] data;
    logic [RESP_W-1:0]      resp;
  } lite_r_s;

  // ****************************************
  // state machines
  // ****************************************
  typedef enum logic [4:0] {
    WS_IDLE  = 5'h01,
    WS_ISSUE = 5'h02,
    WS_RESP  = 5'h04,
    WS_DRAIN = 5'h08,
    WS_BRESP = 5'h10
  } write_state_e;

  typedef enum logic [3:0] {
    RS_IDLE  = 4'h1,
    RS_ISSUE = 4'h2,
    RS_DATA  = 4'h4,
    RS_OUT   = 4'h8
  } read_state_e;

  typedef struct packed {
    write_state_e       st;
    logic [ID_W-1:0]    id;
    logic [ADDR_W-1:0]  start;
    logic [ADDR_W-1:0]  beat;
    logic [ADDR_W-1:0]  piece;
    logic [LEN_W-1:0]   len;
    logic [LEN_W-1:0]   cnt;
    logic [SIZE_W-1:0]  size;
    logic [BURST_W-1:0] burst;
    logic [PROT_W-1:0]  prot;
    logic [RESP_W-1:0]  resp;
    logic               issued;
    logic               aw_ready;
    logic               aw_valid;
    logic               w_valid;
    logic               b_ready;
    logic               sb_valid;
    lite_a_s            aw;
    lite_w_s            w;
  } wr_ctx_s;

  typedef struct packed {
    read_state_e          st;
    logic [ID_W-1:0]      id;
    logic [ADDR_W-1:0]    start;
    logic [ADDR_W-1:0]    beat;
    logic [ADDR_W-1:0]    piece;
    logic [LEN_W-1:0]     len;
    logic [LEN_W-1:0]     cnt;
    logic [SIZE_W-1:0]    size;
    logic [BURST_W-1:0]   burst;
    logic [PROT_W-1:0]    prot;
    logic [RESP_W-1:0]    resp;
    logic                 ar_ready;
    logic                 ar_valid;
    logic                 r_ready;
    logic                 sr_valid;
    logic                 last;
    logic [UP_DATA_W-1:0] data;
    lite_a_s              ar;
  } rd_ctx_s;

  localparam wr_ctx_s WR_CTX_RST = '{st: WS_IDLE, aw: '0, w: '0, default: '0};
  localparam rd_ctx_s RD_CTX_RST = '{st: RS_IDLE, ar: '0, default: '0};

  // ****************************************
  // address and response helpers
  // ****************************************
  function automatic logic [ADDR_W-1:0] size_mask(input logic [SIZE_W-1:0] size);
    size_mask = (ADDR_W'(1) << size) - ADDR_W'(1);
  endfunction : size_mask

  function automatic logic [ADDR_W-1:0] next_beat(input logic [ADDR_W-1:0]  addr,
                                                  input logic [ADDR_W-1:0]  start,
                                                  input logic [LEN_W-1:0]   len,
                                                  input logic [SIZE_W-1:0]  size,
                                                  input logic [BURST_W-1:0] burst);
    logic [ADDR_W-1:0] incr;
    logic [ADDR_W-1:0] wmask;
    incr  = (addr & ~size_mask(size)) + (ADDR_ONE << size);
    wmask = ((ADDR_W'(len) + ADDR_ONE) << size) - ADDR_ONE;
    if (burst == BURST_FIXED) begin
      next_beat = start;
    end else if (burst == BURST_WRAP) begin
      next_beat = (start & ~wmask) | (incr & wmask);
    end else begin
      next_beat = incr;
    end
  endfunction : next_beat

  function automatic logic [ADDR_W-1:0] next_piece(input logic [ADDR_W-1:0] piece);
    next_piece = (piece & ~(LITE_BYTES - ADDR_ONE)) + LITE_BYTES;
  endfunction : next_piece

  function automatic logic piece_last(input logic [ADDR_W-1:0] piece,
                                      input logic [SIZE_W-1:0] size);
    piece_last = (size <= LITE_SIZE) || ((next_piece(piece) & size_mask(size)) == '0);
  endfunction : piece_last

  // first error wins and stays; an exclusive-okay from below counts as plain okay
  function automatic logic [RESP_W-1:0] merge_resp(input logic [RESP_W-1:0] acc,
                                                   input logic [RESP_W-1:0] resp);
    merge_resp = acc[1] ? acc : (resp[1] ? resp : RESP_OKAY);
  endfunction : merge_resp

  function automatic lite_a_s lite_req(input logic [ID_W-1:0]   id,
                                       input logic [ADDR_W-1:0] addr,
                                       input logic [SIZE_W-1:0] size,
                                       input logic [PROT_W-1:0] prot);
    lite_req = '{id: id, addr: addr, size: (size > LITE_SIZE) ? LITE_SIZE : size, prot: prot};
  endfunction : lite_req

endpackage : bridge_pkg

// File: hdl/burst_to_single_beat_bridge.sv
`timescale 1ns/1ns

// ****************************************
// write data buffer
// ****************************************
module bridge_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock, reset, enable
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             ready_reg;
  logic             ready_next;
  logic             valid_reg;
  logic             valid_next;
  logic             push;
  logic             pop;

  assign in_ready_o  = ready_reg;
  assign out_valid_o = valid_reg;
  assign out_data_o  = mem[rd_ptr_reg];
  assign push        = in_valid_i & ready_reg;
  assign pop         = out_ready_i & valid_reg;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next    = cnt_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_W'(1);
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_W'(1);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + CNT_W'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - CNT_W'(1);
    end
    ready_next = (cnt_next != CNT_FULL);
    valid_next = (cnt_next != '0);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
      ready_reg  <= 1'b0;
      valid_reg  <= 1'b0;
    end else if (ce_i) begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
      ready_reg  <= ready_next;
      valid_reg  <= valid_next;
    end
  end

  // storage needs no reset; valid_reg guards every read
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

endmodule : bridge_fifo

// ****************************************
// bridge top
// ****************************************
module burst_to_single_beat_bridge (
  // clock, reset, enable
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  // upstream write address
  input  wire logic                s_aw_valid_i,
  input  wire bridge_pkg::up_a_s   s_aw_i,
  output logic                     s_aw_ready_o,
  // upstream write data
  input  wire logic                s_w_valid_i,
  input  wire bridge_pkg::up_w_s   s_w_i,
  output logic                     s_w_ready_o,
  // upstream write response
  output logic                     s_b_valid_o,
  output bridge_pkg::resp_s        s_b_o,
  input  wire logic                s_b_ready_i,
  // upstream read address
  input  wire logic                s_ar_valid_i,
  input  wire bridge_pkg::up_a_s   s_ar_i,
  output logic                     s_ar_ready_o,
  // upstream read data
  output logic                     s_r_valid_o,
  output bridge_pkg::up_r_s        s_r_o,
  input  wire logic                s_r_ready_i,
  // lite write address
  output logic                     m_aw_valid_o,
  output bridge_pkg::lite_a_s      m_aw_o,
  input  wire logic                m_aw_ready_i,
  // lite write data
  output logic                     m_w_valid_o,
  output bridge_pkg::lite_w_s      m_w_o,
  input  wire logic                m_w_ready_i,
  // lite write response
  input  wire logic                m_b_valid_i,
  input  wire bridge_pkg::resp_s   m_b_i,
  output logic                     m_b_ready_o,
  // lite read address
  output logic                     m_ar_valid_o,
  output bridge_pkg::lite_a_s      m_ar_o,
  input  wire logic                m_ar_ready_i,
  // lite read data
  input  wire logic                m_r_valid_i,
  input  wire bridge_pkg::lite_r_s m_r_i,
  output logic                     m_r_ready_o
);
  import bridge_pkg::*;

  wr_ctx_s           wr;
  wr_ctx_s           wn;
  rd_ctx_s           rd;
  rd_ctx_s           rn;
  up_wd_s            wd_in;
  up_wd_s            wd_head;
  logic              wd_valid;
  logic              wd_pop;
  logic [LANE_W-1:0] w_lane;
  logic [LANE_W-1:0] r_lane;

  // ****************************************
  // write data path
  // ****************************************
  assign wd_in = '{data: s_w_i.data, strb: s_w_i.strb};

  bridge_fifo #(
    .WIDTH ($bits(up_wd_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_wdata_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (s_w_valid_i),
    .in_data_i   (wd_in),
    .in_ready_o  (s_w_ready_o),
    .out_valid_o (wd_valid),
    .out_data_o  (wd_head),
    .out_ready_i (wd_pop)
  );

  assign w_lane = wr.piece[UP_OFF_W-1:LITE_OFF_W];
  assign r_lane = rd.piece[UP_OFF_W-1:LITE_OFF_W];

  // ****************************************
  // write sequencer
  // ****************************************
  always_comb begin
    wn     = wr;
    wd_pop = 1'b0;
    if (wr.aw_valid && m_aw_ready_i) begin
      wn.aw_valid = 1'b0;
    end
    if (wr.w_valid && m_w_ready_i) begin
      wn.w_valid = 1'b0;
    end
    unique case (wr.st)
      WS_IDLE: begin
        if (wr.aw_ready && s_aw_valid_i) begin
          wn.aw_ready = 1'b0;
          wn.id       = s_aw_i.id;
          wn.start    = s_aw_i.addr;
          wn.beat     = s_aw_i.addr;
          wn.piece    = s_aw_i.addr;
          wn.len      = s_aw_i.len;
          wn.size     = s_aw_i.size;
          wn.burst    = s_aw_i.burst;
          wn.prot     = s_aw_i.prot;
          wn.cnt      = '0;
          wn.resp     = RESP_OKAY;
          wn.issued   = 1'b0;
          // cache bits are never looked at: the lite side is device non-bufferable
          wn.st       = s_aw_i.lock ? WS_DRAIN : WS_ISSUE;
        end else begin
          wn.aw_ready = 1'b1;
        end
      end
      WS_ISSUE: begin
        if (!wr.issued) begin
          if (wd_valid) begin
            wn.issued   = 1'b1;
            wn.aw_valid = 1'b1;
            wn.w_valid  = 1'b1;
            wn.aw       = lite_req(wr.id, wr.piece, wr.size, wr.prot);
            wn.w.data   = wd_head.data[w_lane*LITE_DATA_W +: LITE_DATA_W];
            wn.w.strb   = wd_head.strb[w_lane*LITE_STRB_W +: LITE_STRB_W];
          end
        end else if (!wn.aw_valid && !wn.w_valid) begin
          wn.b_ready = 1'b1;
          wn.st      = WS_RESP;
        end
      end
      WS_RESP: begin
        if (wr.b_ready && m_b_valid_i) begin
          wn.b_ready = 1'b0;
          wn.issued  = 1'b0;
          wn.resp    = merge_resp(wr.resp, m_b_i.resp);
          if (piece_last(wr.piece, wr.size)) begin
            wd_pop = 1'b1;
            if (wr.cnt == wr.len) begin
              wn.sb_valid = 1'b1;
              wn.st       = WS_BRESP;
            end else begin
              wn.cnt   = wr.cnt + LEN_W'(1);
              wn.beat  = next_beat(wr.beat, wr.start, wr.len, wr.size, wr.burst);
              wn.piece = next_beat(wr.beat, wr.start, wr.len, wr.size, wr.burst);
              wn.st    = WS_ISSUE;
            end
          end else begin
            wn.piece = next_piece(wr.piece);
            wn.st    = WS_ISSUE;
          end
        end
      end
      WS_DRAIN: begin
        // data is swallowed without a lite write so memory stays untouched
        if (wd_valid) begin
          wd_pop = 1'b1;
          if (wr.cnt == wr.len) begin
            wn.resp     = RESP_OKAY;
            wn.sb_valid = 1'b1;
            wn.st       = WS_BRESP;
          end else begin
            wn.cnt = wr.cnt + LEN_W'(1);
          end
        end
      end
      WS_BRESP: begin
        if (s_b_ready_i) begin
          wn.sb_valid = 1'b0;
          wn.st       = WS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr <= WR_CTX_RST;
    end else if (ce_i) begin
      wr <= wn;
    end
  end

  // ****************************************
  // read sequencer
  // ****************************************
  always_comb begin
    rn = rd;
    unique case (rd.st)
      RS_IDLE: begin
        if (rd.ar_ready && s_ar_valid_i) begin
          rn.ar_ready = 1'b0;
          rn.id       = s_ar_i.id;
          rn.start    = s_ar_i.addr;
          rn.beat     = s_ar_i.addr;
          rn.piece    = s_ar_i.addr;
          rn.len      = s_ar_i.len;
          rn.size     = s_ar_i.size;
          rn.burst    = s_ar_i.burst;
          rn.prot     = s_ar_i.prot;
          rn.cnt      = '0;
          rn.resp     = RESP_OKAY;
          rn.data     = '0;
          rn.ar       = lite_req(s_ar_i.id, s_ar_i.addr, s_ar_i.size, s_ar_i.prot);
          rn.ar_valid = 1'b1;
          rn.st       = RS_ISSUE;
        end else begin
          rn.ar_ready = 1'b1;
        end
      end
      RS_ISSUE: begin
        // one lite read in flight at a time keeps same-id answers in order
        if (m_ar_ready_i) begin
          rn.ar_valid = 1'b0;
          rn.r_ready  = 1'b1;
          rn.st       = RS_DATA;
        end
      end
      RS_DATA: begin
        if (m_r_valid_i) begin
          rn.r_ready = 1'b0;
          rn.data[r_lane*LITE_DATA_W +: LITE_DATA_W] = m_r_i.data;
          rn.resp    = merge_resp(rd.resp, m_r_i.resp);
          if (piece_last(rd.piece, rd.size)) begin
            rn.sr_valid = 1'b1;
            rn.last     = (rd.cnt == rd.len);
            rn.st       = RS_OUT;
          end else begin
            rn.piece    = next_piece(rd.piece);
            rn.ar       = lite_req(rd.id, next_piece(rd.piece), rd.size, rd.prot);
            rn.ar_valid = 1'b1;
            rn.st       = RS_ISSUE;
          end
        end
      end
      RS_OUT: begin
        if (s_r_ready_i) begin
          rn.sr_valid = 1'b0;
          if (rd.last) begin
            rn.st = RS_IDLE;
          end else begin
            rn.cnt      = rd.cnt + LEN_W'(1);
            rn.beat     = next_beat(rd.beat, rd.start, rd.len, rd.size, rd.burst);
            rn.piece    = rn.beat;
            rn.resp     = RESP_OKAY;
            rn.data     = '0;
            rn.ar       = lite_req(rd.id, rn.beat, rd.size, rd.prot);
            rn.ar_valid = 1'b1;
            rn.st       = RS_ISSUE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd <= RD_CTX_RST;
    end else if (ce_i) begin
      rd <= rn;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_aw_ready_o = wr.aw_ready;
  assign s_b_valid_o  = wr.sb_valid;
  assign s_b_o        = '{id: wr.id, resp: wr.resp};
  assign m_aw_valid_o = wr.aw_valid;
  assign m_aw_o       = wr.aw;
  assign m_w_valid_o  = wr.w_valid;
  assign m_w_o        = wr.w;
  assign m_b_ready_o  = wr.b_ready;
  assign s_ar_ready_o = rd.ar_ready;
  assign s_r_valid_o  = rd.sr_valid;
  assign s_r_o        = '{id: rd.id, data: rd.data, resp: rd.resp, last: rd.last};
  assign m_ar_valid_o = rd.ar_valid;
  assign m_ar_o       = rd.ar;
  assign m_r_ready_o  = rd.r_ready;

endmodule : burst_to_single_beat_bridge

// File: verification/bridge_monitor.sv
`timescale 1ns/1ns
module bridge_monitor
  import bridge_pkg::*;
(
  input wire logic    ref_clk_i, rst_n_i, s_aw_valid_i, s_aw_ready_o, s_b_valid_o, s_b_ready_i, s_r_valid_o,
  input wire logic    s_r_ready_i, m_aw_valid_o, m_aw_ready_i, m_ar_valid_o, m_ar_ready_i, m_r_ready_o,
  input wire up_a_s   s_aw_i,
  input wire resp_s   s_b_o,
  input wire up_r_s   s_r_o,
  input wire lite_a_s m_aw_o, m_ar_o
);
  logic excl_reg;
  logic excl_next;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // an exclusive write stays open from its address until its answer
  always_comb begin
    excl_next = excl_reg;
    if (s_aw_valid_i && s_aw_ready_o) excl_next = s_aw_i.lock;
    if (s_b_valid_o && s_b_ready_i) excl_next = 1'b0;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) excl_reg <= 1'b0;
    else excl_reg <= excl_next;
  end
  property p_awh; m_aw_valid_o && !m_aw_ready_i |=> m_aw_valid_o && $stable(m_aw_o); endproperty
  a_awh: assert property (p_awh) else $error("aw not held");
  property p_aw1; m_aw_valid_o && m_aw_ready_i |=> !m_aw_valid_o; endproperty
  a_aw1: assert property (p_aw1) else $error("second aw at once");
  property p_ar1; m_ar_valid_o && m_ar_ready_i |=> !m_ar_valid_o && m_r_ready_o; endproperty
  a_ar1: assert property (p_ar1) else $error("ar not single");
  property p_sz; m_aw_valid_o |-> m_aw_o.size <= LITE_SIZE; endproperty
  a_sz: assert property (p_sz) else $error("aw too wide");
  property p_bh; s_b_valid_o && !s_b_ready_i |=> s_b_valid_o && $stable(s_b_o); endproperty
  a_bh: assert property (p_bh) else $error("b not held");
  property p_rh; s_r_valid_o && !s_r_ready_i |=> s_r_valid_o && $stable(s_r_o); endproperty
  a_rh: assert property (p_rh) else $error("r not held");
  property p_exa; excl_reg |-> !m_aw_valid_o; endproperty
  a_exa: assert property (p_exa) else $error("exclusive forwarded");
  property p_exb; excl_reg && s_b_valid_o |-> s_b_o.resp == RESP_OKAY; endproperty
  a_exb: assert property (p_exb) else $error("exclusive not failed");
endmodule : bridge_monitor

// File: verification/lite_slave_model.sv
`timescale 1ns/1ns
module lite_slave_model
  import bridge_pkg::*;
(
  input  wire logic    ref_clk_i, rst_n_i, slow_i, aw_valid_i, w_valid_i, b_ready_i, ar_valid_i, r_ready_i,
  input  wire lite_a_s aw_i, ar_i,
  output logic         aw_ready_o, w_ready_o, b_valid_o, ar_ready_o, r_valid_o,
  output resp_s        b_o,
  output lite_r_s      r_o
);
  logic tick_reg;
  wire logic go = tick_reg || !slow_i;
  // error regions by address so merged answers are predictable
  function automatic logic [RESP_W-1:0] err(input logic [ADDR_W-1:0] x);
    err = (x[7:4] == 4'hE) ? 2'h2 : (x[7:4] == 4'hD) ? 2'h3 : 2'h0;
  endfunction : err
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {tick_reg, aw_ready_o, w_ready_o, b_valid_o, ar_ready_o, r_valid_o} <= '0;
      b_o <= '0;
      r_o <= '0;
    end else begin
      tick_reg <= ~tick_reg;
      {aw_ready_o, w_ready_o} <= {2{aw_valid_i && w_valid_i && !aw_ready_o && !b_valid_o && go}};
      ar_ready_o <= ar_valid_i && !ar_ready_o && !r_valid_o && go;
      if (aw_ready_o) begin
        b_valid_o <= 1'b1;
        b_o <= '{id: aw_i.id, resp: err(aw_i.addr)};
      end else if (b_valid_o && b_ready_i) b_valid_o <= 1'b0;
      else if (!b_valid_o) b_o <= ~b_o;
      if (ar_ready_o) begin
        r_valid_o <= 1'b1;
        r_o <= '{id: ar_i.id, data: ar_i.addr, resp: err(ar_i.addr)};
      end else if (r_valid_o && r_ready_i) r_valid_o <= 1'b0;
      else if (!r_valid_o) r_o <= ~r_o;
    end
  end
endmodule : lite_slave_model

// File: verification/burst_to_single_beat_bridge_test.sv
`timescale 1ns/1ns
module burst_to_single_beat_bridge_test;
  import bridge_pkg::*;
  logic ref_clk_i, rst_n_i, ce_i, s_aw_valid_i, s_aw_ready_o, s_w_valid_i, s_w_ready_o, s_b_valid_o, s_b_ready_i;
  logic s_ar_valid_i, s_ar_ready_o, s_r_valid_o, s_r_ready_i, m_aw_valid_o, m_aw_ready_i, m_w_valid_o, m_w_ready_i;
  logic m_b_valid_i, m_b_ready_o, m_ar_valid_o, m_ar_ready_i, m_r_valid_i, m_r_ready_o, slow_i;
  up_a_s   s_aw_i, s_ar_i, cur, a, tbl[6];
  up_w_s   s_w_i;
  up_r_s   s_r_o;
  resp_s   s_b_o, m_b_i;
  lite_a_s m_aw_o, m_ar_o;
  lite_w_s m_w_o, ew[$], gw[$];
  lite_r_s m_r_i;
  logic [31:0] eq[$], gq[$];
  logic [63:0] ed[$], wd[16], r;
  logic [1:0]  er[$], wres;
  logic [7:0]  ws[16];
  int seed = 38445, failures = 0, n_compared = 0, k;
  burst_to_single_beat_bridge i_dut (.*);
  lite_slave_model i_slave (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .slow_i(slow_i), .aw_valid_i(m_aw_valid_o),
    .w_valid_i(m_w_valid_o), .b_ready_i(m_b_ready_o), .ar_valid_i(m_ar_valid_o), .r_ready_i(m_r_ready_o),
    .aw_i(m_aw_o), .ar_i(m_ar_o), .aw_ready_o(m_aw_ready_i), .w_ready_o(m_w_ready_i), .b_valid_o(m_b_valid_i),
    .ar_ready_o(m_ar_ready_i), .r_valid_o(m_r_valid_i), .b_o(m_b_i), .r_o(m_r_i));
  task automatic chk(input string nm, input logic [63:0] e, g);
    n_compared++;
    if (e !== g) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // ****************************************
  // expected pieces, lanes and merged answers
  // ****************************************
  task automatic expect_all(input up_a_s x, input bit isw);
    logic [31:0] b, p, m;
    logic [63:0] d;
    logic [1:0]  e;
    int i;
    eq = {}; ew = {}; ed = {}; er = {}; wres = 2'h0; b = x.addr;
    m = ((32'(x.len) + 32'h1) << x.size) - 32'h1;
    for (i = 0; i <= x.len; i++) begin
      p = b; d = '0; e = 2'h0;
      do begin
        if (!e[1]) e = (p[7:4] == 4'hE) ? 2'h2 : (p[7:4] == 4'hD) ? 2'h3 : 2'h0;
        eq.push_back(p);
        ew.push_back('{wd[i][p[2]*32 +: 32], ws[i][p[2]*4 +: 4]});
        d[p[2]*32 +: 32] = p;
        p = (p & ~32'h3) + 32'h4;
      end while (x.size == 3'h3 && p[2:0] != 3'h0);
      ed.push_back(d);
      er.push_back(e);
      if (!wres[1]) wres = e;
      b = (x.burst == 2'h0) ? x.addr : (x.burst == 2'h2) ? (x.addr & ~m) | ((b + (32'h1 << x.size)) & m)
        : (b & ~((32'h1 << x.size) - 32'h1)) + (32'h1 << x.size);
    end
    if (isw && x.lock) begin eq = {}; ew = {}; wres = 2'h0; end
  endtask : expect_all
  task automatic run(input up_a_s x, input bit isw);
    int i;
    cur = x; gq = {}; gw = {};
    for (i = 0; i < 16; i++) begin wd[i] = {$random(seed), $random(seed)}; ws[i] = 8'($random(seed)); end
    expect_all(x, isw);
    if (isw) begin
      s_aw_i <= x; s_aw_valid_i <= 1'b1; s_w_valid_i <= 1'b1; s_w_i <= '{wd[0], ws[0], x.len == 8'h0};
      i = 0;
      do begin
        @(posedge ref_clk_i);
        if (s_aw_valid_i && s_aw_ready_o) s_aw_valid_i <= 1'b0;
        if (s_w_valid_i && s_w_ready_o) begin
          i++;
          if (i > x.len) s_w_valid_i <= 1'b0;
          else s_w_i <= '{wd[i], ws[i], i == x.len};
        end
      end while (s_aw_valid_i || s_w_valid_i);
      forever begin @(posedge ref_clk_i); if (s_b_valid_o && s_b_ready_i) break; s_b_ready_i <= 1'($random(seed)); end
      s_b_ready_i <= 1'b0;
      chk("bid", x.id, s_b_o.id);
      chk("bresp", wres, s_b_o.resp);
    end else begin
      s_ar_i <= x; s_ar_valid_i <= 1'b1;
      do @(posedge ref_clk_i); while (!s_ar_ready_o);
      s_ar_valid_i <= 1'b0;
      for (i = 0; i <= x.len; i++) begin
        forever begin @(posedge ref_clk_i); if (s_r_valid_o && s_r_ready_i) break; s_r_ready_i <= 1'($random(seed)); end
        chk("rdata", ed[i], s_r_o.data);
        chk("rresp", er[i], s_r_o.resp);
        chk("rlast", i == x.len, s_r_o.last);
        chk("rid", x.id, s_r_o.id);
      end
      s_r_ready_i <= 1'b0;
    end
    chk("pieces", eq.size(), gq.size());
    for (i = 0; i < eq.size(); i++) chk("addr", eq[i], gq[i]);
    for (i = 0; i < gw.size(); i++) chk("wdata", ew[i], gw[i]);
  endtask : run
  always @(posedge ref_clk_i) begin
    if (m_aw_valid_o && m_aw_ready_i) begin
      gq.push_back(m_aw_o.addr);
      chk("aw id", cur.id, m_aw_o.id);
      chk("aw prot", cur.prot, m_aw_o.prot);
    end
    if (m_ar_valid_o && m_ar_ready_i) begin
      gq.push_back(m_ar_o.addr);
      chk("ar prot", cur.prot, m_ar_o.prot);
    end
    if (m_w_valid_o && m_w_ready_i) gw.push_back(m_w_o);
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #3000000;
    failures++;
    close_out();
  end
  initial begin
    {rst_n_i, s_aw_valid_i, s_w_valid_i, s_b_ready_i, s_ar_valid_i, s_r_ready_i, slow_i} = '0;
    s_aw_i = '0; s_ar_i = '0; s_w_i = '0; ce_i = 1'b1;
    // aligned narrow incr, unaligned wide, wrap with slave error before decode error, incr with decode error before slave error, fixed wide, exclusive
    tbl = '{'{4'h3, 32'h100, 8'h3, 3'h2, 2'h1, 1'b0, 4'hF, 3'h5}, '{4'h9, 32'h1002, 8'h1, 3'h3, 2'h1, 1'b0, 4'h0, 3'h2},
            '{4'hC, 32'hE8, 8'hF, 3'h2, 2'h2, 1'b0, 4'h3, 3'h7}, '{4'h5, 32'hD8, 8'h7, 3'h2, 2'h1, 1'b0, 4'h2, 3'h1},
            '{4'h6, 32'h40, 8'h2, 3'h3, 2'h0, 1'b0, 4'hB, 3'h4}, '{4'h7, 32'h80, 8'h1, 3'h2, 2'h1, 1'b1, 4'h0, 3'h6}};
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    for (k = 0; k < 12; k++) begin
      slow_i <= k[0];
      run(tbl[k % 6], k < 6);
    end
    for (k = 0; k < 40; k++) begin
      r = {$random(seed), $random(seed)};
      a = r[$bits(up_a_s)-1:0];
      a.addr &= 32'h1FF;
      a.len &= 8'h7;
      a.lock = 1'b0;
      a.size &= 3'h3;
      if (a.burst == 2'h3) a.burst = 2'h1;
      if (a.burst == 2'h2) begin a.len = 8'h3; a.addr = a.addr >> a.size << a.size; end
      slow_i <= k[1];
      run(a, k[0]);
    end
    close_out();
  end
endmodule : burst_to_single_beat_bridge_test
bind burst_to_single_beat_bridge bridge_monitor i_mon (.*);
